// ===== hdl/mtr_regs.vh
// Constants for the mission time reference block.
// Assumes a 100 MHz reference clock; every time but the clock period has its own unit and a derived cycle count.
`ifndef MTR_REGS_VH
`define MTR_REGS_VH

`define MTR_CLK_PERIOD_NS   10
`define MTR_MET_WIDTH       32
`define MTR_COARSE_WIDTH    16
`define MTR_FINE_WIDTH      6
`define MTR_PPS_PERIOD_MS   1000
`define MTR_PPS_CYCLES      ((`MTR_PPS_PERIOD_MS * 1000000) / `MTR_CLK_PERIOD_NS)
`define MTR_SHOT_PERIOD_US  100
`define MTR_SHOT_CYCLES     ((`MTR_SHOT_PERIOD_US * 1000) / `MTR_CLK_PERIOD_NS)
`define MTR_FRAME_PERIOD_MS 20
`define MTR_FRAME_CYCLES    ((`MTR_FRAME_PERIOD_MS * 1000000) / `MTR_CLK_PERIOD_NS)
`define MTR_IET_PERIOD_NS   40
`define MTR_IET_DIV         (`MTR_IET_PERIOD_NS / `MTR_CLK_PERIOD_NS)

`endif

// ===== hdl/mtr_time_ref.v
// Mission time reference: elapsed counters, one-second pulse, shot and frame ticks, event tags.
// Assumes clk is the 100 MHz reference oscillator; pin inputs are asynchronous to it.
//
// Summary of operation
// - A free-running 32-bit mission elapsed counter counts every enabled reference cycle and wraps.
// - Each external GPS second pulse captures the mission elapsed count into its own latch.
// - An internal second pulse is made from the reference clock and captures the count into a second latch.
// - The internal second pulse is driven out to the event-timer cards and the frame formatter.
// - The coarse ruler count advances once per reference cycle, so each count is 10 ns.
// - The coarse ruler count tags transmit pulses only; return pulses take their coarse tag from the band count.
// - The coarse ruler count opens and closes the range window; a separate bin counter times each histogram bin.
// - Coarse and fine counts are joined to tag shot and return events to about 156 ps.
// - The ruler clock is divided to 25 MHz to advance a private instrument elapsed counter.
// - The instrument elapsed count tags the internal second pulse and the first shot tick after it.
// - A 10 kHz shot-period tick zeroes the coarse start count, so start tags follow the last tick.
// - Return tags are measured from the start of their downlink band, not from the shot tick.
// - A 50 Hz frame tick latches new range-window values and is signalled to the processor.
`include "mtr_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module mtr_time_ref #(
  parameter [31:0] PPS_CYCLES   = `MTR_PPS_CYCLES,
  parameter [31:0] SHOT_CYCLES  = `MTR_SHOT_CYCLES,
  parameter [31:0] FRAME_CYCLES = `MTR_FRAME_CYCLES
) (
  // Clock, reset, enable
  input  wire                          clk,
  input  wire                          rst_n,
  input  wire                          clkEn,
  // Asynchronous pins
  input  wire                          gpsPps,
  input  wire                          startPulse,
  input  wire                          returnPulse,
  input  wire                          bandStart,
  // Same-domain inputs from the fine interpolator and the processor
  input  wire [`MTR_FINE_WIDTH-1:0]    startFine,
  input  wire [`MTR_FINE_WIDTH-1:0]    returnFine,
  input  wire [`MTR_COARSE_WIDTH-1:0]  winOpenIn,
  input  wire [`MTR_COARSE_WIDTH-1:0]  winCloseIn,
  input  wire [`MTR_COARSE_WIDTH-1:0]  binLenIn,
  // Elapsed time outputs
  output reg  [`MTR_MET_WIDTH-1:0]     metCount_r,
  output reg  [`MTR_MET_WIDTH-1:0]     gpsLatch_r,
  output reg                           gpsLatchStb_r,
  output reg  [`MTR_MET_WIDTH-1:0]     ppsLatch_r,
  output reg                           intPps_r,
  output reg  [`MTR_MET_WIDTH-1:0]     ietCount_r,
  output reg  [`MTR_MET_WIDTH-1:0]     ietPpsTag_r,
  output reg  [`MTR_MET_WIDTH-1:0]     ietShotTag_r,
  output reg                           ietShotStb_r,
  // Shot and frame ticks and the coarse ruler count
  output reg                           shotTick_r,
  output reg                           frameTick_r,
  output reg  [`MTR_COARSE_WIDTH-1:0]  coarseCount_r,
  // Event tags
  output reg  [`MTR_COARSE_WIDTH+`MTR_FINE_WIDTH-1:0] startTag_r,
  output reg                           startStb_r,
  output reg  [`MTR_COARSE_WIDTH+`MTR_FINE_WIDTH-1:0] returnTag_r,
  output reg                           returnStb_r,
  // Range window and histogram
  output reg                           rangeWin_r,
  output reg                           binTick_r
);

  localparam CW = `MTR_COARSE_WIDTH;
  localparam FW = `MTR_FINE_WIDTH;
  // The divider limit is worked out 32 bits wide and cut to the two counter bits on purpose.
  localparam [31:0] IET_DIV_FULL = `MTR_IET_DIV - 1;
  localparam [1:0]  IET_DIV_LAST = IET_DIV_FULL[1:0];

  // Wrap test shared by the three period counters.
  function atLast;
    input [31:0] cnt;
    input [31:0] period;
    begin
      atLast = (cnt == period - 32'h0000_0001);
    end
  endfunction

  // Pin synchronisers: stage 1 feeds stage 2 only; stage 3 is for edge detection.
  reg  [3:0] sync1_r;
  reg  [3:0] sync2_r;
  reg  [3:0] sync3_r;
  wire [3:0] pinRise = sync2_r & ~sync3_r;
  wire gpsRise    = pinRise[0];
  wire startRise  = pinRise[1];
  wire returnRise = pinRise[2];
  wire bandRise   = pinRise[3];

  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else if (clkEn) begin
      // A pin that moves while clkEn is low is only seen once the enable returns.
      sync1_r <= {bandStart, returnPulse, startPulse, gpsPps};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Period counters.
  // Periods are parameters so a bench can shorten them; the defaults give the real rates.
  reg  [31:0]   ppsCnt_r;
  reg  [31:0]   shotCnt_r;
  reg  [31:0]   frameCnt_r;
  reg  [1:0]    ietDiv_r;
  reg  [CW-1:0] bandCount_r;
  reg  [CW-1:0] winOpen_r;
  reg  [CW-1:0] winClose_r;
  reg  [CW-1:0] binLen_r;
  reg  [CW-1:0] binCnt_r;
  reg           awaitShot_r;

  // Each period counter wraps at N-1, so its tick lands on enabled edge N after reset.
  wire ppsWrap   = atLast(ppsCnt_r, PPS_CYCLES);
  wire shotWrap  = atLast(shotCnt_r, SHOT_CYCLES);
  wire frameWrap = atLast(frameCnt_r, FRAME_CYCLES);
  wire ietStep   = (ietDiv_r == IET_DIV_LAST);
  wire winNxt    = (coarseCount_r >= winOpen_r) && (coarseCount_r < winClose_r);

  always @(posedge clk) begin
    if (!rst_n) begin
      // Every register clears here; pins may move as soon as reset lets go.
      metCount_r    <= 32'h0000_0000;
      gpsLatch_r    <= 32'h0000_0000;
      gpsLatchStb_r <= 1'b0;
      ppsLatch_r    <= 32'h0000_0000;
      intPps_r      <= 1'b0;
      ppsCnt_r      <= 32'h0000_0000;
      shotCnt_r     <= 32'h0000_0000;
      frameCnt_r    <= 32'h0000_0000;
      ietDiv_r      <= 2'h0;
      ietCount_r    <= 32'h0000_0000;
      ietPpsTag_r   <= 32'h0000_0000;
      ietShotTag_r  <= 32'h0000_0000;
      ietShotStb_r  <= 1'b0;
      awaitShot_r   <= 1'b0;
      shotTick_r    <= 1'b0;
      frameTick_r   <= 1'b0;
      coarseCount_r <= {CW{1'b0}};
      bandCount_r   <= {CW{1'b0}};
      startTag_r    <= {(CW+FW){1'b0}};
      startStb_r    <= 1'b0;
      returnTag_r   <= {(CW+FW){1'b0}};
      returnStb_r   <= 1'b0;
      winOpen_r     <= {CW{1'b0}};
      winClose_r    <= {CW{1'b0}};
      binLen_r      <= {CW{1'b0}};
      binCnt_r      <= {CW{1'b0}};
      rangeWin_r    <= 1'b0;
      binTick_r     <= 1'b0;
    end else if (clkEn) begin
      // The mission count is left to wrap; software has to extend it beyond 32 bits.
      metCount_r <= metCount_r + 32'h0000_0001;
      gpsLatchStb_r <= gpsRise;
      if (gpsRise) begin
        gpsLatch_r <= metCount_r;
      end
      // The second is counted in enabled cycles, so holding clkEn low stretches it.
      ppsCnt_r <= ppsWrap ? 32'h0000_0000 : ppsCnt_r + 32'h0000_0001;
      intPps_r <= ppsWrap;
      if (ppsWrap) begin
        ppsLatch_r <= metCount_r;
      end
      // The 25 MHz count is kept as an enable on the reference clock, not a derived clock.
      ietDiv_r <= ietStep ? 2'h0 : ietDiv_r + 2'h1;
      if (ietStep) begin
        ietCount_r <= ietCount_r + 32'h0000_0001;
      end
      if (ppsWrap) begin
        ietPpsTag_r <= ietCount_r;
      end
      // The shot tag fires once per internal second and then waits for the next second.
      // A second pulse in the same cycle as a shot tick rearms for the next tick.
      ietShotStb_r <= awaitShot_r && shotWrap && !ppsWrap;
      if (awaitShot_r && shotWrap && !ppsWrap) begin
        ietShotTag_r <= ietCount_r;
      end
      awaitShot_r <= ppsWrap | (awaitShot_r & ~shotWrap);
      shotCnt_r  <= shotWrap ? 32'h0000_0000 : shotCnt_r + 32'h0000_0001;
      shotTick_r <= shotWrap;
      frameCnt_r  <= frameWrap ? 32'h0000_0000 : frameCnt_r + 32'h0000_0001;
      frameTick_r <= frameWrap;
      // Window values are taken only on the frame tick, so a window never changes mid-frame.
      if (frameWrap) begin
        winOpen_r  <= winOpenIn;
        winClose_r <= winCloseIn;
        binLen_r   <= binLenIn;
      end
      // A start edge reads the count from before its register edge, so an edge that meets
      // the shot tick is tagged with the last count of the old period.
      coarseCount_r <= shotWrap ? {CW{1'b0}} : coarseCount_r + {{(CW-1){1'b0}}, 1'b1};
      // Return tags run from their own band counter; the shot tick never touches it.
      bandCount_r <= bandRise ? {CW{1'b0}} : bandCount_r + {{(CW-1){1'b0}}, 1'b1};
      // Fine counts travel in the low bits of each tag.
      startStb_r <= startRise;
      if (startRise) begin
        startTag_r <= {coarseCount_r, startFine};
      end
      returnStb_r <= returnRise;
      if (returnRise) begin
        returnTag_r <= {bandCount_r, returnFine};
      end
      // The window compare is registered, so the window output trails the count by a cycle.
      rangeWin_r <= winNxt;
      // A zero bin length yields no bin ticks rather than a tick every cycle.
      if (!winNxt || binCnt_r == binLen_r - {{(CW-1){1'b0}}, 1'b1}) begin
        binCnt_r <= {CW{1'b0}};
      end else begin
        binCnt_r <= binCnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      // Only full bins tick; a bin cut short by the window close gives no tick.
      binTick_r <= winNxt && (binLen_r != {CW{1'b0}}) &&
                   (binCnt_r == binLen_r - {{(CW-1){1'b0}}, 1'b1});
    end
  end

endmodule // mtr_time_ref

`default_nettype wire

// ===== test/mtr_time_ref_props.sv
// Concurrent checks on the ports of the mission time reference.
// Assumes pin pulses stay high for at least two reference cycles.
`timescale 1ns/10ps
`default_nettype none
module mtr_time_ref_props #(parameter [31:0] PPS_CYCLES = 32'h28) (
  // Clock, reset, enable and the GPS pin
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        gpsPps,
  // Strobes and ticks
  input wire logic        gpsLatchStb_r,
  input wire logic        intPps_r,
  input wire logic        shotTick_r,
  // Counts and latches
  input wire logic [31:0] metCount_r,
  input wire logic [31:0] gpsLatch_r,
  input wire logic [31:0] ppsLatch_r,
  input wire logic [31:0] ietCount_r,
  input wire logic [15:0] coarseCount_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Enabled cycles since the last internal pulse, so a late pulse is caught too.
  logic [31:0] gap_r;
  always_ff @(posedge clk)
    if (!rst_n) gap_r <= 32'h0;
    else if (clkEn) gap_r <= intPps_r ? 32'h1 : gap_r + 32'h1;
  property p_met; clkEn |=> metCount_r == $past(metCount_r) + 32'h1; endproperty
  a_met: assert property (p_met) else $error("mission count step wrong");
  property p_gps_time;
    $rose(gpsPps) && clkEn ##1 gpsPps && clkEn ##1 clkEn |=> gpsLatchStb_r;
  endproperty
  a_gps_time: assert property (p_gps_time) else $error("gps strobe late");
  property p_gps_val; gpsLatchStb_r |-> gpsLatch_r == $past(metCount_r); endproperty
  a_gps_val: assert property (p_gps_val) else $error("gps latch value wrong");
  property p_pps_val; intPps_r |-> ppsLatch_r == $past(metCount_r); endproperty
  a_pps_val: assert property (p_pps_val) else $error("pps latch value wrong");
  property p_pps_gap;
    gap_r <= PPS_CYCLES && (!intPps_r || gap_r == PPS_CYCLES);
  endproperty
  a_pps_gap: assert property (p_pps_gap) else $error("pps period wrong");
  property p_shot_zero; shotTick_r |-> coarseCount_r == 16'h0; endproperty
  a_shot_zero: assert property (p_shot_zero) else $error("coarse not zeroed");
  property p_coarse;
    clkEn |=> shotTick_r || coarseCount_r == $past(coarseCount_r) + 16'h1;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse step wrong");
  property p_iet;
    $changed(ietCount_r) |-> ietCount_r == $past(ietCount_r) + 32'h1 ##1 $stable(ietCount_r)[*3];
  endproperty
  a_iet: assert property (p_iet) else $error("instrument count rate wrong");
  c_gps: cover property (gpsLatchStb_r);
  c_pps: cover property (intPps_r);
  c_shot: cover property (shotTick_r);
endmodule // mtr_time_ref_props
bind mtr_time_ref mtr_time_ref_props #(.PPS_CYCLES(PPS_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .gpsPps(gpsPps), .gpsLatchStb_r(gpsLatchStb_r),
  .intPps_r(intPps_r), .shotTick_r(shotTick_r), .metCount_r(metCount_r),
  .gpsLatch_r(gpsLatch_r), .ppsLatch_r(ppsLatch_r), .ietCount_r(ietCount_r),
  .coarseCount_r(coarseCount_r));
`default_nettype wire

// ===== test/mtr_gps_model.sv
// GPS receiver model that sends one second pulse on request.
// Assumes requests are spaced wider than the four-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module mtr_gps_model (
  input wire logic clk,
  input wire logic req,
  output var logic gpsPps
);
  // The line idles low between pulses.
  initial gpsPps = 1'b0;
  always @(posedge clk) begin
    if (req) begin
      #1 gpsPps = 1'b1;
      repeat (4) @(posedge clk);
      #1 gpsPps = 1'b0;
    end
  end
endmodule // mtr_gps_model
`default_nettype wire

// ===== test/mtr_time_ref_tb.sv
// Self-checking bench for the mission time reference with shortened periods.
// Assumes the bound checker and the GPS model beside the block.
`timescale 1ns/10ps
`default_nettype none
module mtr_time_ref_tb;
  logic        clk, rst_n, clkEn, req, gpsPps, startPulse, returnPulse, bandStart;
  logic        gpsLatchStb_r, intPps_r, ietShotStb_r, shotTick_r, frameTick_r, rangeWin_r;
  logic        startStb_r, returnStb_r, binTick_r;
  logic [5:0]  fine;
  logic [15:0] coarseCount_r, wo = 16'h2, wc = 16'h5, bl = 16'h2;
  logic [21:0] startTag_r, returnTag_r;
  logic [31:0] metCount_r, gpsLatch_r, ppsLatch_r, cyc, ietCount_r, ietPpsTag_r, ietShotTag_r;
  int          n_mismatch, num_checks;
  // Launch cycle, expected GPS latch, expected start tag, fine count.
  logic [31:0] rows [3][4] = '{'{32'hC, 32'hF, 32'h180, 32'h0},
    '{32'h14, 32'h17, 32'h185, 32'h5}, '{32'h1D, 32'h20, 32'h1FF, 32'h3F}};
  mtr_time_ref #(.PPS_CYCLES(32'h28), .SHOT_CYCLES(32'h8), .FRAME_CYCLES(32'h18)) dut (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .gpsPps(gpsPps), .startPulse(startPulse),
    .returnPulse(returnPulse), .bandStart(bandStart), .startFine(fine), .returnFine(fine),
    .winOpenIn(wo), .winCloseIn(wc), .binLenIn(bl), .metCount_r(metCount_r),
    .gpsLatch_r(gpsLatch_r), .gpsLatchStb_r(gpsLatchStb_r), .ppsLatch_r(ppsLatch_r),
    .intPps_r(intPps_r), .ietCount_r(ietCount_r), .ietPpsTag_r(ietPpsTag_r),
    .ietShotTag_r(ietShotTag_r), .ietShotStb_r(ietShotStb_r), .shotTick_r(shotTick_r),
    .frameTick_r(frameTick_r), .coarseCount_r(coarseCount_r), .startTag_r(startTag_r),
    .startStb_r(startStb_r), .returnTag_r(returnTag_r), .returnStb_r(returnStb_r),
    .rangeWin_r(rangeWin_r), .binTick_r(binTick_r));
  mtr_gps_model gps (.clk(clk), .req(req), .gpsPps(gpsPps));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Edge number since reset release; expectations are counted from it.
  always @(posedge clk) cyc <= rst_n ? cyc + 32'h1 : 32'h0;
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task stop_test;
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task upto(input logic [31:0] n);
    repeat (300) if (cyc < n) begin @(posedge clk); #1; end
    if (cyc < n) begin n_mismatch++; stop_test; end
  endtask
  initial begin
    {rst_n, clkEn, req, startPulse, returnPulse, bandStart} = 6'h10;
    {fine, n_mismatch, num_checks} = '0;
    repeat (10) @(posedge clk);
    #1 chk("metCount_r", metCount_r, 32'h0);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      upto(rows[i][0]);
      fine = rows[i][3][5:0];
      {req, startPulse, returnPulse, bandStart} = 4'hF;
      @(posedge clk);
      #1 req = 1'b0;
      upto(rows[i][0] + 32'h4);
      {startPulse, returnPulse, bandStart} = 3'h0;
      chk("gpsLatch_r", gpsLatch_r, rows[i][1]);
      chk("startTag_r", startTag_r, rows[i][2]);
    end
    upto(32'h28);
    chk("intPps_r", intPps_r, 32'h1);
    chk("ppsLatch_r", ppsLatch_r, 32'h27);
    upto(32'h30);
    chk("coarseCount_r", coarseCount_r, 32'h0);
    chk("ietShotStb_r", ietShotStb_r, 32'h1);
    chk("ietCount_r", ietCount_r, 32'hC);
    chk("ietPpsTag_r", ietPpsTag_r, 32'h9);
    chk("ietShotTag_r", ietShotTag_r, 32'hB);
    // Band edge first, then start and return together two cycles later.
    bandStart = 1'b1;
    upto(32'h32);
    {bandStart, startPulse, returnPulse} = 3'h3;
    fine = 6'h0A;
    upto(32'h34);
    chk("binTick_r", binTick_r, 32'h1);
    upto(32'h35);
    chk("binTick_r", binTick_r, 32'h0);
    chk("startStb_r", startStb_r, 32'h1);
    chk("startTag_r", startTag_r, 32'h10A);
    // The band count reads zero a cycle after its own edge, so two cycles apart read one.
    chk("returnStb_r", returnStb_r, 32'h1);
    chk("returnTag_r", returnTag_r, 32'h4A);
    {startPulse, returnPulse} = 2'h0;
    // New window close and a zero bin length take effect only at the next frame tick.
    bl = 16'h0;
    wc = 16'h4;
    upto(32'h48);
    chk("frameTick_r", frameTick_r, 32'h1);
    upto(32'h4B);
    chk("rangeWin_r", rangeWin_r, 32'h1);
    upto(32'h4C);
    chk("binTick_r", binTick_r, 32'h0);
    upto(32'h4D);
    chk("rangeWin_r", rangeWin_r, 32'h0);
    upto(32'h4E);
    chk("rangeWin_r", rangeWin_r, 32'h0);
    clkEn = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("metCount_r", metCount_r, 32'h4E);
    stop_test;
  end
endmodule // mtr_time_ref_tb
`default_nettype wire
